// ---- logic/soh_pkg.sv ----
// Package: constants, register map and types for the servo-on command handler
package soh_pkg;

  // Command codes and phases
  localparam logic [7:0] SOH_CMD_SERVO_ON = 8'h31;
  localparam logic [2:0] SOH_PHASE_FIRST = 3'h2;
  localparam logic [2:0] SOH_PHASE_LAST = 3'h3;

  // Register byte offsets
  localparam logic [7:0] SOH_OFS_CTRL = 8'h00;
  localparam logic [7:0] SOH_OFS_ALLOC = 8'h04;
  localparam logic [7:0] SOH_OFS_ACTIVE = 8'h08;
  localparam logic [7:0] SOH_OFS_STATUS = 8'h0c;
  localparam logic [7:0] SOH_OFS_IRQ_STS = 8'h10;
  localparam logic [7:0] SOH_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] SOH_OFS_OPT_MON = 8'h18;

  // AXI responses
  localparam logic [1:0] SOH_RESP_OKAY = 2'b00;
  localparam logic [1:0] SOH_RESP_SLVERR = 2'b10;

  // Remap digit value that selects the allocation table
  localparam logic [3:0] SOH_REMAP_ON = 4'h1;
  localparam logic [3:0] SOH_REMAP_RESET = 4'h0;

  // Allocation table: six 5-bit fields {enable, position}
  localparam int SOH_ALLOC_W = 5;
  localparam int SOH_FN_COUNT = 6;
  localparam int SOH_FN_ACC = 0;
  localparam int SOH_FN_GAIN = 1;
  localparam int SOH_FN_VPPI = 2;
  localparam int SOH_FN_PICLR = 3;
  localparam int SOH_FN_FWD = 4;
  localparam int SOH_FN_REV = 5;
  localparam int SOH_ALLOC_EN_BIT = 4;
  localparam logic [3:0] SOH_DEF_POS_ACC = 4'h3;
  localparam logic [3:0] SOH_DEF_POS_GAIN = 4'h8;
  localparam logic [3:0] SOH_DEF_POS_VPPI = 4'hc;
  localparam logic [3:0] SOH_DEF_POS_PICLR = 4'hd;
  localparam logic [3:0] SOH_DEF_POS_FWD = 4'he;
  localparam logic [3:0] SOH_DEF_POS_REV = 4'hf;
  localparam logic [29:0] SOH_ALLOC_DEFAULT = {
    1'b1, SOH_DEF_POS_REV, 1'b1, SOH_DEF_POS_FWD, 1'b1, SOH_DEF_POS_PICLR,
    1'b1, SOH_DEF_POS_VPPI, 1'b1, SOH_DEF_POS_GAIN, 1'b1, SOH_DEF_POS_ACC};
  localparam logic [15:0] SOH_OPT_DEFAULT_MASK = 16'hf318;

  // Interrupt status bits
  localparam int SOH_IRQ_W = 2;
  localparam int SOH_IRQ_WARN = 0;
  localparam int SOH_IRQ_DONE = 1;

  // Drive status bits
  localparam int SOH_ST_MOTOR = 0;
  localparam int SOH_ST_HARD_STOP = 1;
  localparam int SOH_ST_ALARM = 2;
  localparam int SOH_ST_POWER = 3;
  localparam int SOH_ST_ENC_DONE = 4;
  localparam int SOH_ST_WARN = 5;

  typedef enum logic [1:0] {
    SOH_MOTOR_OFF = 2'b00,
    SOH_MOTOR_ON = 2'b01
  } soh_motor_t;

endpackage

// ---- logic/soh_option_decode.sv ----
// Option word decoder driven by a function allocation table
`timescale 1ns/100ps
module soh_option_decode
  import soh_pkg::*;
(
  input wire logic [15:0] option_word,
  input wire logic [29:0] alloc,
  output logic [1:0] accel_filter_sel,
  output logic [1:0] gain_sel,
  output logic speed_loop_p_mode,
  output logic position_integral_clear,
  output logic fwd_torque_limit,
  output logic rev_torque_limit,
  output logic [15:0] used_word
);

  function automatic logic [4:0] fn_field(input logic [29:0] tbl, input int idx);
    fn_field = tbl[idx*SOH_ALLOC_W +: SOH_ALLOC_W];
  endfunction

  // Unallocated function reads as zero
  function automatic logic pick(input logic [15:0] w, input logic [4:0] fld, input logic hi);
    logic [3:0] pos;
    pos = fld[3:0] + {3'h0, hi};
    pick = fld[SOH_ALLOC_EN_BIT] & w[pos];
  endfunction

  logic [15:0] mask;

  always_comb begin
    logic [4:0] fld;
    fld = 5'h00;
    mask = 16'h0000;
    for (int i = 0; i < SOH_FN_COUNT; i++) begin
      fld = fn_field(alloc, i);
      if (fld[SOH_ALLOC_EN_BIT]) begin
        mask[fld[3:0]] = 1'b1;
        if (i == SOH_FN_ACC || i == SOH_FN_GAIN) begin
          mask[4'(fld[3:0] + 4'h1)] = 1'b1;
        end
      end
    end
  end

  // Bits with no function behave as zero
  assign used_word = option_word & mask;
  assign accel_filter_sel = {pick(option_word, fn_field(alloc, SOH_FN_ACC), 1'b1),
                             pick(option_word, fn_field(alloc, SOH_FN_ACC), 1'b0)};
  assign gain_sel = {pick(option_word, fn_field(alloc, SOH_FN_GAIN), 1'b1),
                     pick(option_word, fn_field(alloc, SOH_FN_GAIN), 1'b0)};
  assign speed_loop_p_mode = pick(option_word, fn_field(alloc, SOH_FN_VPPI), 1'b0);
  assign position_integral_clear = pick(option_word, fn_field(alloc, SOH_FN_PICLR), 1'b0);
  assign fwd_torque_limit = pick(option_word, fn_field(alloc, SOH_FN_FWD), 1'b0);
  assign rev_torque_limit = pick(option_word, fn_field(alloc, SOH_FN_REV), 1'b0);

endmodule

// ---- logic/soh_servo_on.sv ----
// Servo-on command handler with option decoding and AXI4-Lite registers
//
// Notes on behaviour
// - Servo-on code 31H, phases 2 or 3 only, echoed in response, asynchronous.
// - Accepted servo-on energises the motor and marks it ready for operation.
// - Alarm, power off, hard stop or pending encoder power: warn, discard.
// - Option word travels in command bytes three and four, decoded here.
// - Decoded option functions apply while the carrying command executes.
// - Default layout: filter D3-D4, gain D8-D9, D12, D13, D14, D15.
// - Remap digit equal to one selects positions from the allocation table.
// - New allocation takes effect only after power cycle or reconfigure; here only reconfig_cmd loads it, sys_rst reloads the default.
// - Bits without an allocated function are treated as zero.
// - Hard stop status is the OR of both hard stop inputs.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module soh_servo_on
  import soh_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_option,
  input wire logic cmd_has_option,
  input wire logic [2:0] comm_phase,
  input wire logic reconfig_cmd,
  input wire logic alarm_flag,
  input wire logic main_power_on_flag,
  input wire logic hard_stop_in1,
  input wire logic hard_stop_in2,
  input wire logic abs_encoder_fitted,
  input wire logic encoder_power_on_done,
  output logic rsp_valid,
  output logic [7:0] rsp_code,
  output logic rsp_warning,
  output logic motor_energised,
  output logic ready_for_operation,
  output logic hard_stop_flag,
  output logic command_warning_one,
  output logic [1:0] accel_filter_sel,
  output logic [1:0] gain_sel,
  output logic speed_loop_p_mode,
  output logic position_integral_clear,
  output logic fwd_torque_limit,
  output logic rev_torque_limit,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        old[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge_strb = old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Command qualification

  soh_motor_t motor_reg;
  logic hard_stop_reg;
  logic warn_reg;
  logic [3:0] remap_param_reg;
  logic [29:0] alloc_param_reg;
  logic [3:0] active_remap_reg;
  logic [29:0] active_alloc_reg;
  logic [SOH_IRQ_W-1:0] irq_sts_reg;
  logic [SOH_IRQ_W-1:0] irq_mask_reg;
  logic [15:0] opt_mon_reg;

  logic phase_ok;
  logic servo_req;
  logic blocked;
  logic fault;
  logic accept;
  logic reject;
  logic opt_strobe;

  assign phase_ok = (comm_phase == SOH_PHASE_FIRST) || (comm_phase == SOH_PHASE_LAST);
  assign servo_req = cmd_valid && (cmd_code == SOH_CMD_SERVO_ON) && phase_ok;
  assign fault = alarm_flag || !main_power_on_flag || hard_stop_reg;
  assign blocked = fault || (abs_encoder_fitted && !encoder_power_on_done);
  assign accept = servo_req && !blocked;
  assign reject = servo_req && blocked;
  assign opt_strobe = accept || (cmd_valid && cmd_has_option && cmd_code != SOH_CMD_SERVO_ON);

  // Hard stop status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hard_stop_reg <= 1'b0;
    end else begin
      hard_stop_reg <= hard_stop_in1 || hard_stop_in2;
    end
  end

  // Motor state: faults drop power after it is on
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      motor_reg <= SOH_MOTOR_OFF;
    end else begin
      case (motor_reg)
        SOH_MOTOR_OFF: begin
          if (accept) begin
            motor_reg <= SOH_MOTOR_ON;
          end
        end
        SOH_MOTOR_ON: begin
          if (fault && !accept) begin
            motor_reg <= SOH_MOTOR_OFF;
          end
        end
        default: begin
          motor_reg <= SOH_MOTOR_OFF;
        end
      endcase
    end
  end

  // Response echo and warning
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_code <= 8'h00;
      rsp_warning <= 1'b0;
      warn_reg <= 1'b0;
    end else begin
      rsp_valid <= servo_req;
      if (servo_req) begin
        rsp_code <= cmd_code;
        rsp_warning <= reject;
        warn_reg <= reject;
      end
    end
  end

  assign motor_energised = (motor_reg == SOH_MOTOR_ON);
  assign ready_for_operation = (motor_reg == SOH_MOTOR_ON);
  assign hard_stop_flag = hard_stop_reg;
  assign command_warning_one = warn_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Option decoding

  logic [29:0] alloc_in;
  logic [1:0] dec_acc;
  logic [1:0] dec_gain;
  logic dec_vppi;
  logic dec_piclr;
  logic dec_fwd;
  logic dec_rev;
  logic [15:0] dec_used;

  assign alloc_in = (active_remap_reg == SOH_REMAP_ON) ? active_alloc_reg : SOH_ALLOC_DEFAULT;

  soh_option_decode u_decode (
    .option_word(cmd_option),
    .alloc(alloc_in),
    .accel_filter_sel(dec_acc),
    .gain_sel(dec_gain),
    .speed_loop_p_mode(dec_vppi),
    .position_integral_clear(dec_piclr),
    .fwd_torque_limit(dec_fwd),
    .rev_torque_limit(dec_rev),
    .used_word(dec_used)
  );

  // Functions held for the carrying command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accel_filter_sel <= 2'b00;
      gain_sel <= 2'b00;
      speed_loop_p_mode <= 1'b0;
      position_integral_clear <= 1'b0;
      fwd_torque_limit <= 1'b0;
      rev_torque_limit <= 1'b0;
      opt_mon_reg <= 16'h0000;
    end else if (opt_strobe) begin
      accel_filter_sel <= dec_acc;
      gain_sel <= dec_gain;
      speed_loop_p_mode <= dec_vppi;
      position_integral_clear <= dec_piclr;
      fwd_torque_limit <= dec_fwd;
      rev_torque_limit <= dec_rev;
      opt_mon_reg <= dec_used;
    end
  end

  // Active allocation loads only on reset or reconfigure
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active_remap_reg <= SOH_REMAP_RESET;
      active_alloc_reg <= SOH_ALLOC_DEFAULT;
    end else if (reconfig_cmd) begin
      active_remap_reg <= remap_param_reg;
      active_alloc_reg <= alloc_param_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic [SOH_IRQ_W-1:0] irq_set;
  logic [SOH_IRQ_W-1:0] irq_clr;
  logic [31:0] rd_data;
  logic rd_hit;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SOH_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr_reg)
        SOH_OFS_CTRL, SOH_OFS_ALLOC, SOH_OFS_IRQ_STS, SOH_OFS_IRQ_MASK: begin
          s_axi_bresp <= SOH_RESP_OKAY;
        end
        SOH_OFS_ACTIVE, SOH_OFS_STATUS, SOH_OFS_OPT_MON: begin
          s_axi_bresp <= SOH_RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= SOH_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Parameter registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remap_param_reg <= SOH_REMAP_RESET;
      alloc_param_reg <= SOH_ALLOC_DEFAULT;
      irq_mask_reg <= '0;
    end else if (do_write) begin
      case (aw_addr_reg)
        SOH_OFS_CTRL: begin
          remap_param_reg <= 4'(merge_strb({28'h0, remap_param_reg}, w_data_reg, w_strb_reg));
        end
        SOH_OFS_ALLOC: begin
          alloc_param_reg <= 30'(merge_strb({2'b00, alloc_param_reg}, w_data_reg, w_strb_reg));
        end
        SOH_OFS_IRQ_MASK: begin
          if (w_strb_reg[0]) begin
            irq_mask_reg <= w_data_reg[SOH_IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky events, write one to clear, set wins
  assign irq_set = {accept, reject};
  assign irq_clr = (do_write && aw_addr_reg == SOH_OFS_IRQ_STS && w_strb_reg[0]) ?
                   w_data_reg[SOH_IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_sts_reg <= '0;
    end else begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_sts_reg & irq_mask_reg);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      SOH_OFS_CTRL: rd_data = {28'h0, remap_param_reg};
      SOH_OFS_ALLOC: rd_data = {2'b00, alloc_param_reg};
      SOH_OFS_ACTIVE: rd_data = {active_remap_reg[1:0], active_alloc_reg};
      SOH_OFS_STATUS: begin
        rd_data[SOH_ST_MOTOR] = motor_energised;
        rd_data[SOH_ST_HARD_STOP] = hard_stop_reg;
        rd_data[SOH_ST_ALARM] = alarm_flag;
        rd_data[SOH_ST_POWER] = main_power_on_flag;
        rd_data[SOH_ST_ENC_DONE] = encoder_power_on_done;
        rd_data[SOH_ST_WARN] = warn_reg;
      end
      SOH_OFS_IRQ_STS: rd_data = {30'h0, irq_sts_reg};
      SOH_OFS_IRQ_MASK: rd_data = {30'h0, irq_mask_reg};
      SOH_OFS_OPT_MON: rd_data = {16'h0000, opt_mon_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SOH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? SOH_RESP_OKAY : SOH_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_servo_req;
    cmd_valid && cmd_code == SOH_CMD_SERVO_ON && phase_ok;
  endsequence

  sequence s_echo;
    rsp_valid && rsp_code == SOH_CMD_SERVO_ON;
  endsequence

  property p_echo;
    @(posedge clk) disable iff (sys_rst) s_servo_req |=> s_echo;
  endproperty
  a_echo: assert property (p_echo) else $error("servo-on not echoed");

  property p_energise;
    @(posedge clk) disable iff (sys_rst) (s_servo_req and !blocked) |=> s_echo ##0
      (motor_energised && !rsp_warning) ##1 (motor_energised || $past(fault));
  endproperty
  a_energise: assert property (p_energise) else $error("motor not energised");

  property p_warn;
    @(posedge clk) disable iff (sys_rst) (s_servo_req and blocked) |=>
      rsp_warning && command_warning_one && irq_sts_reg[SOH_IRQ_WARN] && !$rose(motor_energised);
  endproperty
  a_warn: assert property (p_warn) else $error("blocked servo-on not warned");

  property p_hard_stop;
    @(posedge clk) disable iff (sys_rst) ##1 hard_stop_flag == $past(hard_stop_in1 || hard_stop_in2);
  endproperty
  a_hard_stop: assert property (p_hard_stop) else $error("hard stop status wrong");

  property p_default_layout;
    @(posedge clk) disable iff (sys_rst) (opt_strobe && active_remap_reg != SOH_REMAP_ON) |=>
      accel_filter_sel == $past(cmd_option[4:3]) && gain_sel == $past(cmd_option[9:8]) &&
      {rev_torque_limit, fwd_torque_limit, position_integral_clear, speed_loop_p_mode}
      == $past(cmd_option[15:12]);
  endproperty
  a_default_layout: assert property (p_default_layout) else $error("default decode wrong");

  property p_unused_zero;
    @(posedge clk) disable iff (sys_rst) (opt_strobe && active_remap_reg != SOH_REMAP_ON) |=>
      opt_mon_reg == ($past(cmd_option) & SOH_OPT_DEFAULT_MASK);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused option bit seen");

  property p_remap_fwd;
    @(posedge clk) disable iff (sys_rst)
      (opt_strobe && active_remap_reg == SOH_REMAP_ON && active_alloc_reg[24]) |=>
      fwd_torque_limit == $past(cmd_option[active_alloc_reg[23:20]]);
  endproperty
  a_remap_fwd: assert property (p_remap_fwd) else $error("remapped decode wrong");

  property p_alloc_hold;
    @(posedge clk) disable iff (sys_rst) !reconfig_cmd |=>
      $stable(active_alloc_reg) && $stable(active_remap_reg);
  endproperty
  a_alloc_hold: assert property (p_alloc_hold) else $error("allocation changed early");

  property p_option_hold;
    @(posedge clk) disable iff (sys_rst) !opt_strobe |=>
      $stable(accel_filter_sel) && $stable(gain_sel) && $stable(fwd_torque_limit);
  endproperty
  a_option_hold: assert property (p_option_hold) else $error("option changed mid-command");

endmodule

// ---- verification/soh_host_model.sv ----
// Host controller model: sends command frames to the servo-on handler
`timescale 1ns/100ps
module soh_host_model
  import soh_pkg::*;
(
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_code,
  input wire logic rsp_warning,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_option,
  output logic cmd_has_option,
  output logic [2:0] comm_phase
);
  logic coord_set_reg;

  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_option = 16'h0000;
    cmd_has_option = 1'b0;
    comm_phase = SOH_PHASE_FIRST;
    coord_set_reg = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame: code in byte one, option in bytes three and four
  task automatic send(input logic [7:0] code, input logic [15:0] opt, input logic has);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_option <= opt;
    cmd_has_option <= has;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~code;
    cmd_option <= ~opt;
  endtask

  task automatic set_phase(input logic [2:0] p);
    @(posedge clk);
    comm_phase <= p;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reference position taken again after each completed servo-on
  always @(posedge clk) begin
    if (rsp_valid && rsp_code === SOH_CMD_SERVO_ON && rsp_warning === 1'b0) begin
      coord_set_reg <= 1'b1;
    end
  end
endmodule

// ---- verification/soh_servo_on_bench.sv ----
// Self-checking bench for the servo-on command handler
`timescale 1ns/100ps
module soh_servo_on_bench
  import soh_pkg::*;
;
  logic clk = 0, sys_rst = 1, reconfig_cmd = 0, alarm_flag = 0, main_power_on_flag = 1;
  logic hard_stop_in1 = 0, hard_stop_in2 = 0, abs_encoder_fitted = 0, encoder_power_on_done = 1;
  logic cmd_valid, cmd_has_option, rsp_valid, rsp_warning, motor_energised, ready_for_operation;
  logic [7:0] cmd_code, rsp_code;
  logic [15:0] cmd_option;
  logic [2:0] comm_phase;
  logic hard_stop_flag, command_warning_one, speed_loop_p_mode, position_integral_clear;
  logic fwd_torque_limit, rev_torque_limit, irq;
  logic [1:0] accel_filter_sel, gain_sel, s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  int mismatches = 0, n_tests = 0;

  always #5 clk = ~clk;

  soh_host_model host (.clk(clk), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
    .rsp_warning(rsp_warning), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_option(cmd_option), .cmd_has_option(cmd_has_option), .comm_phase(comm_phase));

  soh_servo_on dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_option(cmd_option), .cmd_has_option(cmd_has_option), .comm_phase(comm_phase),
    .reconfig_cmd(reconfig_cmd), .alarm_flag(alarm_flag),
    .main_power_on_flag(main_power_on_flag), .hard_stop_in1(hard_stop_in1),
    .hard_stop_in2(hard_stop_in2), .abs_encoder_fitted(abs_encoder_fitted),
    .encoder_power_on_done(encoder_power_on_done), .rsp_valid(rsp_valid),
    .rsp_code(rsp_code), .rsp_warning(rsp_warning), .motor_energised(motor_energised),
    .ready_for_operation(ready_for_operation), .hard_stop_flag(hard_stop_flag),
    .command_warning_one(command_warning_one), .accel_filter_sel(accel_filter_sel),
    .gain_sel(gain_sel), .speed_loop_p_mode(speed_loop_p_mode),
    .position_integral_clear(position_integral_clear), .fwd_torque_limit(fwd_torque_limit),
    .rev_torque_limit(rev_torque_limit), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int i = 0; i < 40 && !b; i++) begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (b) s_axi_bready <= 0;
    end
    check(b, 1);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    r = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int i = 0; i < 40 && !r; i++) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 0;
      if (r) s_axi_rready <= 0;
    end
    check(r, 1);
  endtask

  task automatic do_reset();
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
  endtask

  task automatic conds(input logic al, pw, h1, h2, ed);
    @(posedge clk);
    alarm_flag <= al;
    main_power_on_flag <= pw;
    hard_stop_in1 <= h1;
    hard_stop_in2 <= h2;
    encoder_power_on_done <= ed;
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(SOH_OFS_CTRL); check(rdat, 0);
    axi_rd(SOH_OFS_ALLOC); check(rdat, {2'b00, SOH_ALLOC_DEFAULT});
    axi_rd(SOH_OFS_IRQ_MASK); check(rdat, 0);
    axi_wr(SOH_OFS_STATUS, 32'hffffffff); check(resp, SOH_RESP_OKAY);
    axi_rd(SOH_OFS_STATUS); check(rdat, 32'h18);
    axi_rd(8'h1c); check(resp, SOH_RESP_SLVERR);
    check(rdat, 0);
  endtask

  task automatic t_reject();
    abs_encoder_fitted <= 1;
    for (int i = 0; i < 5; i++) begin
      conds(i == 0, i != 1, i == 2, i == 3, i != 4);
      check(hard_stop_flag, i == 2 || i == 3);
      host.send(SOH_CMD_SERVO_ON, 16'hffff, 0);
      @(negedge clk);
      check(rsp_valid, 1);
      check(rsp_warning, 1);
      check(command_warning_one, 1);
      check(motor_energised, 0);
      check(accel_filter_sel, 0);
    end
    check(host.coord_set_reg, 0);
    conds(0, 1, 0, 0, 1);
  endtask

  task automatic t_accept();
    host.send(SOH_CMD_SERVO_ON, 16'ha3ff, 0);
    @(negedge clk);
    check(rsp_valid, 1);
    check(rsp_code, SOH_CMD_SERVO_ON);
    check({rsp_warning, command_warning_one}, 0);
    check({motor_energised, ready_for_operation}, 2'b11);
    check({accel_filter_sel, gain_sel}, 4'hf);
    check({speed_loop_p_mode, position_integral_clear}, 2'b01);
    check({fwd_torque_limit, rev_torque_limit}, 2'b01);
    @(negedge clk);
    check(rsp_valid, 0);
    check(host.coord_set_reg, 1);
    axi_rd(SOH_OFS_OPT_MON); check(rdat, 32'ha318);
    host.send(8'h34, 16'h5000, 1);
    @(negedge clk);
    check(rsp_valid, 0);
    check({speed_loop_p_mode, fwd_torque_limit, accel_filter_sel}, 4'b1100);
    conds(1, 1, 0, 0, 1);
    check(motor_energised, 0);
    conds(0, 1, 0, 0, 1);
  endtask

  task automatic t_phase();
    for (int p = 0; p < 8; p++) begin
      if (p == 2 || p == 3) continue;
      host.set_phase(3'(p));
      host.send(SOH_CMD_SERVO_ON, 16'h0000, 0);
      repeat (2) begin
        @(negedge clk);
        check({rsp_valid, motor_energised}, 0);
      end
    end
    host.set_phase(SOH_PHASE_LAST);
  endtask

  task automatic t_irq();
    axi_rd(SOH_OFS_IRQ_STS); check(rdat, 3);
    check(irq, 0);
    axi_wr(SOH_OFS_IRQ_MASK, 1);
    check(irq, 1);
    axi_wr(SOH_OFS_IRQ_STS, 1);
    axi_rd(SOH_OFS_IRQ_STS); check(rdat, 2);
    check(irq, 0);
    axi_wr(SOH_OFS_IRQ_MASK, 2);
    check(irq, 1);
    axi_wr(SOH_OFS_IRQ_STS, 2);
    check(irq, 0);
    axi_rd(SOH_OFS_IRQ_MASK); check(rdat, 2);
  endtask

  task automatic t_remap();
    axi_wr(SOH_OFS_ALLOC, 32'h01500010);
    axi_wr(SOH_OFS_CTRL, {28'h0, SOH_REMAP_ON});
    host.send(8'h34, 16'h0002, 1);
    @(negedge clk);
    check(accel_filter_sel, 0);
    axi_rd(SOH_OFS_ACTIVE); check(rdat, {2'b00, SOH_ALLOC_DEFAULT});
    @(posedge clk);
    reconfig_cmd <= 1;
    @(posedge clk);
    reconfig_cmd <= 0;
    host.send(8'h34, 16'hfffe, 1);
    @(negedge clk);
    check({accel_filter_sel, gain_sel, rev_torque_limit, fwd_torque_limit}, 6'b100001);
    axi_rd(SOH_OFS_ACTIVE); check(rdat, 32'h41500010);
    axi_rd(SOH_OFS_OPT_MON); check(rdat, 32'h0022);
    do_reset();
    axi_rd(SOH_OFS_ACTIVE); check(rdat, {2'b00, SOH_ALLOC_DEFAULT});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_regs();
    t_reject();
    t_accept();
    t_phase();
    t_irq();
    t_remap();
    results();
  end

  initial begin
    #100000;
    mismatches++;
    results();
  end
endmodule
